/* File: core/intc_consts.vh */
// register map, field positions and encodings of the interrupt priority controller
`ifndef INTC_CONSTS_VH
`define INTC_CONSTS_VH
`define OFS_VECTOR_CONTROL          8'h00
`define OFS_EXEC_STATUS             8'h01
`define OFS_NORMAL_PRIORITY_POINTER 8'h02
`define OFS_HIGH_PRIORITY_VECTOR    8'h03
`define BIT_VECTOR_BASE_SELECT      6
`define BIT_COMPACT_TABLE_ENABLE    5
`define BIT_ROTATING_PRIORITY       0
`define BIT_UNMASKABLE_ACTIVE       7
`define BIT_HIGH_LEVEL_ACTIVE       1
`define BIT_NORMAL_LEVEL_ACTIVE     0
`define RESET_BYTE                  8'h00
`define NO_HIGH_VECTOR              8'h00
`define VEC_RESET                   8'h00
`define VEC_UNMASKABLE              8'h01
`define FIRST_PERIPHERAL_VEC        2
`define COMPACT_VEC_UNMASKABLE      8'h01
`define COMPACT_VEC_HIGH            8'h02
`define COMPACT_VEC_NORMAL          8'h03
`define LVL_NONE                    2'h0
`define LVL_NORMAL                  2'h1
`define LVL_HIGH                    2'h2
`define LVL_UNMASKABLE              2'h3
`define UNLOCK_WINDOW_INSTR         3'h4
`endif

/* File: core/vector_round_picker.v */
// picks the first pending vector after a pointer, wrapping past the top index
`timescale 1ns/1ps
module vector_round_picker #(
    parameter NUM_VECTORS = 32
) (
    input  wire [NUM_VECTORS-1:0] req,
    input  wire [7:0]             after_vec,
    output reg                    found,
    output reg  [7:0]             vec
);
    integer k;
    integer cand;
    // scan from highest offset down so the nearest one after the pointer wins
    always @* begin
        found = 1'b0;
        vec   = 8'h00;
        cand  = 0;
        for (k = NUM_VECTORS; k >= 1; k = k - 1) begin
            cand = (after_vec + k) % NUM_VECTORS;
            if (req[cand]) begin
                found = 1'b1;
                vec   = cand[7:0];
            end
        end
    end
endmodule

/* File: core/unlock_window.v */
// opens a short write window after the io register key is presented
`timescale 1ns/1ps
`include "intc_consts.vh"
module unlock_window (
    input  wire CLK_SYS,
    input  wire RSTN,
    input  wire key_seen,
    input  wire instr_done,
    output wire open
);
    reg [2:0] left;
    // window counts down one per executed instruction
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            left <= 3'h0;
        end else if (key_seen) begin
            left <= `UNLOCK_WINDOW_INSTR;
        end else if (instr_done && left != 3'h0) begin
            left <= left - 3'h1;
        end
    end
    assign open = (left != 3'h0);
endmodule

/* File: core/cpu_interrupt_priority_controller.v */
// interrupt priority controller: levels, scheduling, compact table and executing state
//
// Operation
// [R1] vector named in high priority select register becomes level 1, above normal ones
// [R2] pending level 1 request preempts running level 0 handler, which resumes later
// [R3] after reset all non-unmaskable vectors are normal level until one is promoted
// [R4] fixed or rotating ordering among pending normal requests, chosen by software
// [R5] index 0 is reset, index 1 unmaskable, peripherals numbered upward to n
// [R6] reset, unmaskable and level 1 always beat normal level vectors
// [R7] fixed ordering with zero pointer serves lowest pending vector first
// [R8] pointer value Y gives Y lowest and Y+1 highest normal priority
// [R9] nonzero pointer wraps priority past top index; unmaskable stays on top
// [R10] rotating mode loads pointer with each acknowledged normal vector number
// [R11] software sets rotating enable bit for rotating, clears it for fixed
// [R12] compact mode: unmaskable vector 1, level 1 vector 2, all normal vector 3
// [R13] software writes one to compact enable bit to enter compact mode
// [R14] executing state per level so each handler return restores prior state
// [R15] software writes unlock key then guarded bits within four instructions
// [R16] guarded write without valid unlock leaves the field unchanged
// [R17] only base select and compact enable are guarded; others write freely
// [R18] executing flags set while level handler runs or is preempted, clear on return
// [R19] zero in high priority select means no level 1 vector
// [R20] nothing preempts unmaskable handler; simultaneous unmaskable served lowest first
// [R21] base select one puts vectors at boot start, zero after boot section
// [R22] winning vector presented with request; core acknowledge updates flags and pointer
// [R23] request held until acknowledged or withdrawn; peripheral flags untouched
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "intc_consts.vh"
module cpu_interrupt_priority_controller #(
    parameter                   NUM_VECTORS     = 32,
    parameter [NUM_VECTORS-1:0] UNMASKABLE_MASK = 32'h00000002
) (
    input  wire                   CLK_SYS,
    input  wire                   RSTN,
    input  wire [7:0]             ADDR,
    input  wire [7:0]             WDATA,
    input  wire                   WR,
    input  wire                   RD,
    output reg  [7:0]             RDATA,
    input  wire                   UNLOCK_KEY,
    input  wire                   INSTR_DONE,
    input  wire [NUM_VECTORS-1:0] IRQ_PENDING,
    input  wire                   INT_ACK,
    input  wire                   RETURN_FROM_HANDLER,
    output reg                    INT_REQ,
    output reg  [7:0]             INT_VECTOR,
    output reg  [1:0]             INT_LEVEL,
    output reg                    VECTOR_BASE_SELECT
);
    reg        compact_table_enable;
    reg        rotating_priority_enable;
    reg [7:0]  normal_priority_pointer;
    reg [7:0]  high_priority_vector_select;
    reg        unmaskable_active_flag;
    reg        high_level_active_flag;
    reg        normal_level_active_flag;
    reg [7:0]  win_vec;
    reg        next_req;
    reg [7:0]  next_vec;
    reg [1:0]  next_level;
    reg [7:0]  next_rdata;
    reg [NUM_VECTORS-1:0] normal_req;
    reg [NUM_VECTORS-1:0] nmi_req;
    reg        high_pending;
    wire       guard_open;
    wire       nmi_found;
    wire [7:0] nmi_vec;
    wire       normal_found;
    wire [7:0] normal_vec;
    wire [NUM_VECTORS-1:0] high_hit;
    integer    i;
    genvar     g;

    function is_hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            is_hit = (a == ofs);
        end
    endfunction

    function [7:0] control_byte;
        input base_sel;
        input compact;
        input rotating;
        begin
            control_byte                            = `RESET_BYTE;
            control_byte[`BIT_VECTOR_BASE_SELECT]   = base_sel;
            control_byte[`BIT_COMPACT_TABLE_ENABLE] = compact;
            control_byte[`BIT_ROTATING_PRIORITY]    = rotating;
        end
    endfunction

    function [7:0] status_byte;
        input unmaskable;
        input high;
        input normal;
        begin
            status_byte                           = `RESET_BYTE;
            status_byte[`BIT_UNMASKABLE_ACTIVE]   = unmaskable;
            status_byte[`BIT_HIGH_LEVEL_ACTIVE]   = high;
            status_byte[`BIT_NORMAL_LEVEL_ACTIVE] = normal;
        end
    endfunction

    function [7:0] compact_vec;
        input [1:0] level;
        begin
            case (level)
                `LVL_UNMASKABLE: compact_vec = `COMPACT_VEC_UNMASKABLE;
                `LVL_HIGH:       compact_vec = `COMPACT_VEC_HIGH;
                `LVL_NORMAL:     compact_vec = `COMPACT_VEC_NORMAL;
                default:         compact_vec = `VEC_RESET;
            endcase
        end
    endfunction

    // one select comparator per vector; zero select matches nothing
    generate
        for (g = 0; g < NUM_VECTORS; g = g + 1) begin : high_hit_gen
            localparam [7:0] VEC_NUM = g;
            assign high_hit[g] = (high_priority_vector_select != `NO_HIGH_VECTOR) &&
                                 (high_priority_vector_select == VEC_NUM); // [R19]
        end
    endgenerate

    unlock_window guard (
        .CLK_SYS    (CLK_SYS),
        .RSTN       (RSTN),
        .key_seen   (UNLOCK_KEY),
        .instr_done (INSTR_DONE),
        .open       (guard_open)
    );

    // request classes per vector
    always @* begin
        nmi_req      = {NUM_VECTORS{1'b0}};
        normal_req   = {NUM_VECTORS{1'b0}};
        high_pending = 1'b0;
        for (i = `FIRST_PERIPHERAL_VEC - 1; i < NUM_VECTORS; i = i + 1) begin
            if (UNMASKABLE_MASK[i]) begin
                nmi_req[i] = IRQ_PENDING[i];
            end else if (i >= `FIRST_PERIPHERAL_VEC) begin // [R5]
                if (high_hit[i]) begin // [R1] [R19]
                    high_pending = IRQ_PENDING[i];
                end else begin
                    normal_req[i] = IRQ_PENDING[i]; // [R3]
                end
            end
        end
    end

    // lowest index unmaskable first
    vector_round_picker #(
        .NUM_VECTORS (NUM_VECTORS)
    ) nmi_pick (
        .req       (nmi_req),
        .after_vec (`VEC_RESET),
        .found     (nmi_found),
        .vec       (nmi_vec)
    ); // [R20]

    // normal level starts after the pointer and wraps
    vector_round_picker #(
        .NUM_VECTORS (NUM_VECTORS)
    ) normal_pick (
        .req       (normal_req),
        .after_vec (normal_priority_pointer),
        .found     (normal_found),
        .vec       (normal_vec)
    ); // [R7] [R8] [R9]

    // level choice against the running level
    always @* begin
        next_req   = 1'b0;
        next_vec   = 8'h00;
        next_level = `LVL_NONE;
        win_vec    = 8'h00;
        if (nmi_found && !unmaskable_active_flag) begin // [R20]
            next_req   = 1'b1;
            next_level = `LVL_UNMASKABLE;
            win_vec    = nmi_vec;
        end else if (high_pending && !unmaskable_active_flag && !high_level_active_flag) begin // [R2] [R6]
            next_req   = 1'b1;
            next_level = `LVL_HIGH;
            win_vec    = high_priority_vector_select;
        end else if (normal_found && !unmaskable_active_flag && !high_level_active_flag &&
                     !normal_level_active_flag) begin // [R6]
            next_req   = 1'b1;
            next_level = `LVL_NORMAL;
            win_vec    = normal_vec;
        end
        if (compact_table_enable) begin // [R12]
            next_vec = compact_vec(next_level);
        end else begin
            next_vec = win_vec;
        end
    end

    // request presented and re-evaluated every cycle except the acknowledge cycle, which drops it
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            INT_REQ    <= 1'b0;
            INT_VECTOR <= 8'h00;
            INT_LEVEL  <= `LVL_NONE;
        end else if (INT_REQ && INT_ACK) begin
            INT_REQ    <= 1'b0; // [R22]
            INT_VECTOR <= 8'h00;
            INT_LEVEL  <= `LVL_NONE;
        end else begin
            INT_REQ    <= next_req; // [R23]
            INT_VECTOR <= next_vec;
            INT_LEVEL  <= next_level;
        end
    end

    // executing flags: return clears the top one, acknowledge sets
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            unmaskable_active_flag   <= 1'b0;
            high_level_active_flag   <= 1'b0;
            normal_level_active_flag <= 1'b0;
        end else begin
            if (RETURN_FROM_HANDLER) begin // [R14] [R18]
                if (unmaskable_active_flag) begin
                    unmaskable_active_flag <= 1'b0;
                end else if (high_level_active_flag) begin
                    high_level_active_flag <= 1'b0;
                end else begin
                    normal_level_active_flag <= 1'b0;
                end
            end
            if (INT_REQ && INT_ACK) begin // [R22] [R18]
                case (INT_LEVEL)
                    `LVL_UNMASKABLE: unmaskable_active_flag   <= 1'b1;
                    `LVL_HIGH:       high_level_active_flag   <= 1'b1;
                    `LVL_NORMAL:     normal_level_active_flag <= 1'b1;
                    default:         normal_level_active_flag <= normal_level_active_flag;
                endcase
            end
        end
    end

    // the real vector number behind a compact request
    reg [7:0] acked_vec;
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            acked_vec <= 8'h00;
        end else if (!(INT_REQ && INT_ACK)) begin
            acked_vec <= win_vec;
        end
    end

    // configuration registers
    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            VECTOR_BASE_SELECT          <= 1'b0;
            compact_table_enable        <= 1'b0;
            rotating_priority_enable    <= 1'b0;
            normal_priority_pointer     <= `RESET_BYTE;
            high_priority_vector_select <= `NO_HIGH_VECTOR; // [R3]
        end else begin
            if (WR && is_hit(ADDR, `OFS_VECTOR_CONTROL)) begin
                rotating_priority_enable <= WDATA[`BIT_ROTATING_PRIORITY]; // [R4] [R11] [R17]
                if (guard_open) begin // [R15] [R16] [R17]
                    VECTOR_BASE_SELECT   <= WDATA[`BIT_VECTOR_BASE_SELECT]; // [R21]
                    compact_table_enable <= WDATA[`BIT_COMPACT_TABLE_ENABLE]; // [R13]
                end
            end
            if (WR && is_hit(ADDR, `OFS_HIGH_PRIORITY_VECTOR)) begin
                high_priority_vector_select <= WDATA; // [R1]
            end
            if (INT_REQ && INT_ACK && INT_LEVEL == `LVL_NORMAL && rotating_priority_enable) begin
                normal_priority_pointer <= acked_vec; // [R10]
            end else if (WR && is_hit(ADDR, `OFS_NORMAL_PRIORITY_POINTER)) begin
                normal_priority_pointer <= WDATA; // [R8]
            end
        end
    end

    // read data one cycle after the strobe
    always @* begin
        next_rdata = 8'h00;
        if (is_hit(ADDR, `OFS_VECTOR_CONTROL)) begin
            next_rdata = control_byte(VECTOR_BASE_SELECT, compact_table_enable, rotating_priority_enable);
        end else if (is_hit(ADDR, `OFS_EXEC_STATUS)) begin
            next_rdata = status_byte(unmaskable_active_flag, high_level_active_flag, normal_level_active_flag);
        end else if (is_hit(ADDR, `OFS_NORMAL_PRIORITY_POINTER)) begin
            next_rdata = normal_priority_pointer;
        end else if (is_hit(ADDR, `OFS_HIGH_PRIORITY_VECTOR)) begin
            next_rdata = high_priority_vector_select;
        end
    end

    always @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule

/* File: tb/intc_asserts.sv */
// port checker for the interrupt priority controller
`timescale 1ns/1ps
module intc_chk #(
    parameter NUM_VECTORS = 32
) (
    input wire logic                   CLK_SYS,
    input wire logic                   RSTN,
    input wire logic [7:0]             ADDR,
    input wire logic                   RD,
    input wire logic [7:0]             RDATA,
    input wire logic [NUM_VECTORS-1:0] IRQ_PENDING,
    input wire logic                   INT_ACK,
    input wire logic                   INT_REQ,
    input wire logic [7:0]             INT_VECTOR,
    input wire logic [1:0]             INT_LEVEL
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    property p_ack_drop; $past(INT_ACK && INT_REQ) |-> !INT_REQ; endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("offer kept after ack");
    property p_withdraw; INT_REQ && !INT_ACK && IRQ_PENDING[NUM_VECTORS-1:1] == 0 |=> !INT_REQ; endproperty
    a_withdraw: assert property (p_withdraw) else $error("offer kept after withdrawal");
    property p_unmapped; RD && ADDR > 8'h03 |=> RDATA == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_rsvd; RD && ADDR == 8'h00 |=> RDATA[7] == 1'b0 && RDATA[4:1] == 4'h0; endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control spare bits set");
    property p_stat_rsvd; RD && ADDR == 8'h01 |=> RDATA[6:2] == 5'h00; endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare bits set");
    property p_unmask_vec; INT_REQ && INT_LEVEL == 2'h3 |-> INT_VECTOR == 8'h01; endproperty
    a_unmask_vec: assert property (p_unmask_vec) else $error("unmaskable vector wrong");
    property p_norm_vec; INT_REQ && INT_LEVEL == 2'h1 |-> INT_VECTOR >= 8'h02; endproperty
    a_norm_vec: assert property (p_norm_vec) else $error("normal vector below peripherals");
    property p_req_level; INT_REQ |-> INT_LEVEL != 2'h0; endproperty
    a_req_level: assert property (p_req_level) else $error("offer without level");
endmodule

bind cpu_interrupt_priority_controller intc_chk #(.NUM_VECTORS(NUM_VECTORS)) chk_u (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .IRQ_PENDING(IRQ_PENDING),
    .INT_ACK(INT_ACK), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .INT_LEVEL(INT_LEVEL));

/* File: tb/core_model.sv */
// processor core stand-in: takes offered vectors and returns from handlers
`timescale 1ns/1ps
module core_model (
    input  wire logic       clk,
    input  wire logic       take,
    input  wire logic       ret_go,
    input  wire logic       int_req,
    input  wire logic [7:0] int_vector,
    output logic            int_ack,
    output logic            ret,
    output logic [7:0]      got
);
    initial begin
        int_ack = 1'b0;
        ret = 1'b0;
        got = 8'h00;
    end
    always @(posedge clk) begin
        int_ack <= take && int_req && !int_ack;
        ret <= ret_go;
        if (int_ack && int_req) got <= int_vector;
    end
endmodule

/* File: tb/cpu_interrupt_priority_controller_tb.sv */
// self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
module cpu_interrupt_priority_controller_tb;
    logic        clk_sys, rstn, wr, rd, unlock_key, instr_done, take, ret_go;
    logic        int_ack, ret, int_req, base_sel;
    logic [7:0]  addr, wdata, rdata, int_vector, got;
    logic [1:0]  int_level;
    logic [31:0] irq_pending;
    int          fails, checks_done;

    cpu_interrupt_priority_controller dut_u (
        .CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .UNLOCK_KEY(unlock_key), .INSTR_DONE(instr_done), .IRQ_PENDING(irq_pending), .INT_ACK(int_ack),
        .RETURN_FROM_HANDLER(ret), .INT_REQ(int_req), .INT_VECTOR(int_vector), .INT_LEVEL(int_level),
        .VECTOR_BASE_SELECT(base_sel));
    core_model core_u (.clk(clk_sys), .take(take), .ret_go(ret_go), .int_req(int_req),
        .int_vector(int_vector), .int_ack(int_ack), .ret(ret), .got(got));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic pend(input logic [31:0] p);
        @(posedge clk_sys);
        irq_pending <= p;
    endtask
    task automatic offer(input logic [7:0] v, input logic [1:0] l);
        repeat (3) @(posedge clk_sys);
        #1 chk({int_req, 5'h00, int_level}, {1'b1, 5'h00, l});
        chk(int_vector, v);
    endtask
    task automatic none;
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h00, int_req}, 8'h00);
    endtask
    task automatic ack(input logic [7:0] v);
        @(posedge clk_sys);
        take <= 1'b1;
        @(posedge clk_sys);
        take <= 1'b0;
        @(posedge clk_sys);
        #1 chk(got, v);
    endtask
    task automatic retn;
        @(posedge clk_sys);
        ret_go <= 1'b1;
        @(posedge clk_sys);
        ret_go <= 1'b0;
    endtask
    task automatic unlock;
        @(posedge clk_sys);
        unlock_key <= 1'b1;
        @(posedge clk_sys);
        unlock_key <= 1'b0;
    endtask

    task automatic t_reset;
        for (int i = 0; i < 4; i++) rreg(i[7:0], 8'h00);
        rreg(8'h07, 8'h00);
        wreg(8'h01, 8'hFF);
        rreg(8'h01, 8'h00);
        none();
    endtask
    task automatic t_fixed;
        pend(32'h0000_0220);
        offer(8'h05, 2'h1);
        wreg(8'h02, 8'h05);
        offer(8'h09, 2'h1);
        wreg(8'h02, 8'h09);
        offer(8'h05, 2'h1);
        wreg(8'h02, 8'h00);
        pend(32'h0);
        none();
    endtask
    task automatic t_high;
        pend(32'h0000_0220);
        wreg(8'h03, 8'h09);
        offer(8'h09, 2'h2);
        pend(32'h0000_0222);
        offer(8'h01, 2'h3);
        pend(32'h0000_0220);
        wreg(8'h03, 8'h00);
        offer(8'h05, 2'h1);
        pend(32'h0);
    endtask
    task automatic t_nest;
        pend(32'h0000_0020);
        offer(8'h05, 2'h1);
        ack(8'h05);
        rreg(8'h01, 8'h01);
        wreg(8'h03, 8'h09);
        pend(32'h0000_0200);
        offer(8'h09, 2'h2);
        ack(8'h09);
        rreg(8'h01, 8'h03);
        pend(32'h0000_0002);
        ack(8'h01);
        rreg(8'h01, 8'h83);
        none();
        pend(32'h0);
        retn();
        rreg(8'h01, 8'h03);
        retn();
        rreg(8'h01, 8'h01);
        retn();
        rreg(8'h01, 8'h00);
        wreg(8'h03, 8'h00);
    endtask
    task automatic t_rotate;
        wreg(8'h00, 8'h01);
        rreg(8'h00, 8'h01);
        pend(32'h0000_0220);
        ack(8'h05);
        rreg(8'h02, 8'h05);
        retn();
        offer(8'h09, 2'h1);
        ack(8'h09);
        rreg(8'h02, 8'h09);
        retn();
        offer(8'h05, 2'h1);
        pend(32'h0);
        wreg(8'h00, 8'h00);
        wreg(8'h02, 8'h00);
    endtask
    task automatic t_guard;
        wreg(8'h00, 8'h61);
        rreg(8'h00, 8'h01);
        unlock();
        wreg(8'h00, 8'h61);
        rreg(8'h00, 8'h61);
        chk({7'h00, base_sel}, 8'h01);
        pend(32'h0000_0220);
        offer(8'h03, 2'h1);
        wreg(8'h03, 8'h09);
        offer(8'h02, 2'h2);
        pend(32'h0000_0222);
        offer(8'h01, 2'h3);
        pend(32'h0);
        wreg(8'h03, 8'h00);
        @(posedge clk_sys);
        instr_done <= 1'b1;
        repeat (4) @(posedge clk_sys);
        instr_done <= 1'b0;
        wreg(8'h00, 8'h00);
        rreg(8'h00, 8'h60);
        unlock();
        wreg(8'h00, 8'h00);
        rreg(8'h00, 8'h00);
        chk({7'h00, base_sel}, 8'h00);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #(50 * 4000);
        fails++;
        conclude();
    end
    initial begin
        {rstn, wr, rd, unlock_key, instr_done, take, ret_go} = 7'h00;
        {addr, wdata} = 16'h0000;
        irq_pending = 32'h0;
        fails = 0;
        checks_done = 0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_fixed();
        t_high();
        t_nest();
        t_rotate();
        t_guard();
        conclude();
    end
endmodule
